//--- hdl/mqaf_fifo.sv
module mqaf_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = mqaf_pkg::STAGE_FIFO_DEPTH
) (
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wptr;
		logic [AW-1:0]               rptr;
		logic [AW:0]                 cnt;
		logic [WIDTH-1:0]            out_data;
		logic                        out_valid;
		logic                        in_ready;
	} mqaf_fifo_state_t;

	mqaf_fifo_state_t st_r;
	mqaf_fifo_state_t st_nxt;
	logic             push;
	logic             pop;
	logic             load;

	always_comb
	begin
		st_nxt = st_r;
		push = in_valid_i && st_r.in_ready;
		pop = st_r.out_valid && out_ready_i;
		// Output register refills from storage when empty or being drained
		load = (!st_r.out_valid || pop) && (st_r.cnt != '0);
		if (pop)
			st_nxt.out_valid = 1'h0;
		if (load)
		begin
			st_nxt.out_data = st_r.mem[st_r.rptr];
			st_nxt.out_valid = 1'h1;
			st_nxt.rptr = st_r.rptr + AW'(1);
		end
		if (push)
		begin
			st_nxt.mem[st_r.wptr] = in_data_i;
			st_nxt.wptr = st_r.wptr + AW'(1);
		end
		st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(load);
		st_nxt.in_ready = (st_nxt.cnt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign in_ready_o  = st_r.in_ready;
	assign out_valid_o = st_r.out_valid;
	assign out_data_o  = st_r.out_data;

endmodule : mqaf_fifo

//--- hdl/mqaf_pkg.sv
package mqaf_pkg;

	localparam int NUM_QUEUES       = 32'h10;
	localparam int QUEUE_DEPTH      = 32'h400;
	localparam int DEF_OFFSET_LO    = 32'h8;
	localparam int DEF_OFFSET_HI    = 32'h80;
	localparam int STAGE_FIFO_DEPTH = 32'h20;
	localparam int FLAG_LATENCY     = 32'h2;
	localparam logic AF_N_RESET     = 1'h1;
	localparam logic AE_N_RESET     = 1'h0;

endpackage : mqaf_pkg

//--- hdl/mqaf_top.sv
module mqaf_top #(
	parameter int NUM_Q  = mqaf_pkg::NUM_QUEUES,
	parameter int DEPTH  = mqaf_pkg::QUEUE_DEPTH,
	parameter int STAGES = mqaf_pkg::STAGE_FIFO_DEPTH
) (
	input  wire logic                         clock_i,
	input  wire logic                         rst_i,
	input  wire logic [$clog2(NUM_Q)-1:0]     write_queue_addr_i,
	input  wire logic                         write_addr_strobe_i,
	input  wire logic                         write_en_i,
	output logic                              write_ready_o,
	input  wire logic [$clog2(NUM_Q)-1:0]     read_queue_addr_i,
	input  wire logic                         read_addr_strobe_i,
	input  wire logic                         read_en_i,
	input  wire logic                         default_select_i,
	input  wire logic                         prog_we_i,
	input  wire logic [$clog2(NUM_Q)-1:0]     prog_queue_i,
	input  wire logic [$clog2(DEPTH+1)-1:0]   prog_af_off_i,
	input  wire logic [$clog2(DEPTH+1)-1:0]   prog_ae_off_i,
	output logic                              almost_full_n_o,
	output logic                              almost_empty_n_o
);

	localparam int QA = $clog2(NUM_Q);
	localparam int CW = $clog2(DEPTH+1);
	localparam logic [CW-1:0] DEPTH_C  = CW'(DEPTH);
	localparam logic [CW-1:0] OFF_LO_C = CW'(mqaf_pkg::DEF_OFFSET_LO);
	localparam logic [CW-1:0] OFF_HI_C = CW'(mqaf_pkg::DEF_OFFSET_HI);

	typedef struct packed {
		logic [QA-1:0]             wq_sel;
		logic [QA-1:0]             wq_act;
		logic [QA-1:0]             rq_sel;
		logic [QA-1:0]             rq_act;
		logic [NUM_Q-1:0][CW-1:0]  cnt;
		logic [NUM_Q-1:0][CW-1:0]  af_off;
		logic [NUM_Q-1:0][CW-1:0]  ae_off;
		logic [NUM_Q-1:0]          af_n_stat;
		logic [NUM_Q-1:0]          ae_n_stat;
		logic                      af_n;
		logic                      ae_n;
		logic                      strap_done;
	} mqaf_top_state_t;

	mqaf_top_state_t st_r;
	mqaf_top_state_t st_nxt;
	logic            fifo_valid;
	logic [QA-1:0]   fifo_q;
	logic            commit;
	logic            rd_dec;

	function automatic logic af_hit(input logic [CW-1:0] cnt, input logic [CW-1:0] off);
		af_hit = (cnt >= (DEPTH_C - off));
	endfunction : af_hit

	function automatic logic ae_hit(input logic [CW-1:0] cnt, input logic [CW-1:0] off);
		ae_hit = (cnt <= off);
	endfunction : ae_hit

	// Writes are staged with the queue they were aimed at; a stalled queue backs up into the stage
	mqaf_fifo #(
		.WIDTH (QA),
		.DEPTH (STAGES)
	) u_stage (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.in_valid_i  (write_en_i),
		.in_ready_o  (write_ready_o),
		.in_data_i   (st_r.wq_act),
		.out_valid_o (fifo_valid),
		.out_ready_i (st_r.cnt[fifo_q] != DEPTH_C),
		.out_data_o  (fifo_q)
	);

	always_comb
	begin
		st_nxt = st_r;
		commit = fifo_valid && (st_r.cnt[fifo_q] != DEPTH_C);
		rd_dec = read_en_i && (st_r.cnt[st_r.rq_act] != '0);
		// Selection takes one edge to latch and one more to become active
		if (write_addr_strobe_i)
			st_nxt.wq_sel = write_queue_addr_i;
		st_nxt.wq_act = st_r.wq_sel;
		if (read_addr_strobe_i)
			st_nxt.rq_sel = read_queue_addr_i;
		st_nxt.rq_act = st_r.rq_sel;
		for (int q = 0; q < NUM_Q; q++)
		begin
			if (commit && (fifo_q == QA'(q)))
				st_nxt.cnt[q] = st_nxt.cnt[q] + CW'(1);
			if (rd_dec && (st_r.rq_act == QA'(q)))
				st_nxt.cnt[q] = st_nxt.cnt[q] - CW'(1);
			// First register stage of each flag, kept for every queue
			st_nxt.af_n_stat[q] = !af_hit(st_r.cnt[q], st_r.af_off[q]);
			st_nxt.ae_n_stat[q] = !ae_hit(st_r.cnt[q], st_r.ae_off[q]);
		end
		// Second register stage picks the active queue
		st_nxt.af_n = st_r.af_n_stat[st_r.wq_act];
		st_nxt.ae_n = st_r.ae_n_stat[st_r.rq_act];
		// Strap is sampled on the first edge after reset release
		if (!st_r.strap_done)
		begin
			for (int q = 0; q < NUM_Q; q++)
			begin
				st_nxt.af_off[q] = default_select_i ? OFF_HI_C : OFF_LO_C;
				st_nxt.ae_off[q] = default_select_i ? OFF_HI_C : OFF_LO_C;
			end
			st_nxt.strap_done = 1'h1;
		end
		else if (prog_we_i)
		begin
			st_nxt.af_off[prog_queue_i] = prog_af_off_i;
			st_nxt.ae_off[prog_queue_i] = prog_ae_off_i;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_r <= '0;
			st_r.af_n_stat <= {NUM_Q{mqaf_pkg::AF_N_RESET}};
			st_r.ae_n_stat <= {NUM_Q{mqaf_pkg::AE_N_RESET}};
			st_r.af_n <= mqaf_pkg::AF_N_RESET;
			st_r.ae_n <= mqaf_pkg::AE_N_RESET;
			for (int q = 0; q < NUM_Q; q++)
			begin
				st_r.af_off[q] <= OFF_LO_C;
				st_r.ae_off[q] <= OFF_LO_C;
			end
		end
		else
			st_r <= st_nxt;
	end

	assign almost_full_n_o  = st_r.af_n;
	assign almost_empty_n_o = st_r.ae_n;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	wire logic rd_on_wq  = rd_dec && (st_r.rq_act == st_r.wq_act);
	wire logic com_on_wq = commit && (fifo_q == st_r.wq_act);
	wire logic com_on_rq = commit && (fifo_q == st_r.rq_act);
	wire logic wq_hold   = (st_r.wq_sel == st_r.wq_act) && st_r.strap_done && !prog_we_i;
	wire logic rq_hold   = (st_r.rq_sel == st_r.rq_act) && st_r.strap_done && !prog_we_i;

	wr_select_a: assert property (write_addr_strobe_i ##1 !write_addr_strobe_i |=>
		st_r.wq_act == $past(write_queue_addr_i, 2))
		else $error("write queue not active on second edge");

	rd_select_a: assert property (read_addr_strobe_i ##1 !read_addr_strobe_i |=>
		st_r.rq_act == $past(read_queue_addr_i, 2))
		else $error("read queue not active on second edge");

	af_fall_a: assert property (com_on_wq && wq_hold && !rd_on_wq &&
		!af_hit(st_r.cnt[fifo_q], st_r.af_off[fifo_q]) &&
		af_hit(st_r.cnt[fifo_q] + CW'(1), st_r.af_off[fifo_q]) |-> ##3 !almost_full_n_o)
		else $error("almost full flag not low two cycles after write");

	af_rise_a: assert property (rd_on_wq && wq_hold && !com_on_wq &&
		af_hit(st_r.cnt[st_r.wq_act], st_r.af_off[st_r.wq_act]) &&
		!af_hit(st_r.cnt[st_r.wq_act] - CW'(1), st_r.af_off[st_r.wq_act]) |-> ##3 almost_full_n_o)
		else $error("almost full flag not high two cycles after read");

	ae_fall_a: assert property (rd_dec && rq_hold && !com_on_rq &&
		!ae_hit(st_r.cnt[st_r.rq_act], st_r.ae_off[st_r.rq_act]) &&
		ae_hit(st_r.cnt[st_r.rq_act] - CW'(1), st_r.ae_off[st_r.rq_act]) |-> ##3 !almost_empty_n_o)
		else $error("almost empty flag not low two cycles after read");

	ae_rise_a: assert property (com_on_rq && rq_hold && !rd_dec &&
		ae_hit(st_r.cnt[fifo_q], st_r.ae_off[fifo_q]) &&
		!ae_hit(st_r.cnt[fifo_q] + CW'(1), st_r.ae_off[fifo_q]) |-> ##3 almost_empty_n_o)
		else $error("almost empty flag not high two cycles after write");

	// Queue must have been active for the whole two-stage flag path
	af_active_a: assert property ((st_r.wq_act == $past(st_r.wq_act)) &&
		(st_r.wq_act == $past(st_r.wq_act, 2)) |->
		almost_full_n_o == !af_hit($past(st_r.cnt[st_r.wq_act], 2), $past(st_r.af_off[st_r.wq_act], 2)))
		else $error("almost full flag does not follow the active write queue");

	ae_active_a: assert property ((st_r.rq_act == $past(st_r.rq_act)) &&
		(st_r.rq_act == $past(st_r.rq_act, 2)) |->
		almost_empty_n_o == !ae_hit($past(st_r.cnt[st_r.rq_act], 2), $past(st_r.ae_off[st_r.rq_act], 2)))
		else $error("almost empty flag does not follow the active read queue");

	af_prog_a: assert property (prog_we_i && st_r.strap_done |=>
		st_r.af_off[$past(prog_queue_i)] == $past(prog_af_off_i))
		else $error("almost full offset not loaded");

	ae_prog_a: assert property (prog_we_i && st_r.strap_done |=>
		st_r.ae_off[$past(prog_queue_i)] == $past(prog_ae_off_i))
		else $error("almost empty offset not loaded");

	level_bound_a: assert property (commit |-> st_r.cnt[fifo_q] < DEPTH_C)
		else $error("queue level committed past depth");

	rd_count_a: assert property (rd_dec && (st_r.rq_act != st_r.wq_act) && !com_on_rq |=>
		st_r.cnt[$past(st_r.rq_act)] == $past(st_r.cnt[st_r.rq_act]) - CW'(1))
		else $error("read did not lower the queue level");

	wr_count_a: assert property (commit && (fifo_q != st_r.rq_act) |=>
		st_r.cnt[$past(fifo_q)] == $past(st_r.cnt[fifo_q]) + CW'(1))
		else $error("write did not raise the queue level");

	strap_off_a: assert property ($rose(st_r.strap_done) |->
		st_r.af_off[0] == ($past(default_select_i) ? OFF_HI_C : OFF_LO_C))
		else $error("default offset does not match strap");

	reset_state_a: assert property ($rose(st_r.strap_done) |->
		almost_full_n_o && !almost_empty_n_o && (&st_r.af_n_stat) && (st_r.ae_n_stat == '0))
		else $error("queues not almost empty after reset");

	af_seen_c: cover property (com_on_wq ##2 $fell(almost_full_n_o));
	ae_seen_c: cover property (rd_dec ##2 $fell(almost_empty_n_o));
	switch_c: cover property (write_addr_strobe_i && read_addr_strobe_i ##2 $changed(almost_full_n_o));
	stall_c: cover property (!write_ready_o && write_en_i);

endmodule : mqaf_top

//--- tb/mqaf_ctrl_model.sv
module mqaf_ctrl_model (
	input  wire logic        clock_i,
	output logic [3:0]       write_queue_addr_o,
	output logic             write_addr_strobe_o,
	output logic [3:0]       read_queue_addr_o,
	output logic             read_addr_strobe_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		write_queue_addr_o  = 4'h0;
		write_addr_strobe_o = 1'h0;
		read_queue_addr_o   = 4'h0;
		read_addr_strobe_o  = 1'h0;
	end

	// Address is only meaningful with the strobe; scrambled otherwise
	task sel_w(input logic [3:0] q);
		@(posedge clock_i);
		write_queue_addr_o  <= q;
		write_addr_strobe_o <= 1'h1;
		@(posedge clock_i);
		write_addr_strobe_o <= 1'h0;
		write_queue_addr_o  <= ~q;
	endtask : sel_w

	task sel_r(input logic [3:0] q);
		@(posedge clock_i);
		read_queue_addr_o  <= q;
		read_addr_strobe_o <= 1'h1;
		@(posedge clock_i);
		read_addr_strobe_o <= 1'h0;
		read_queue_addr_o  <= ~q;
	endtask : sel_r
endmodule : mqaf_ctrl_model

//--- tb/mqaf_top_tb.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module mqaf_top_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock_i = 1'h0;
	logic        rst_i   = 1'h1;
	logic [3:0]  wq, rq, pq;
	logic        ws, rs, we, re, pwe, wrdy, af_n, ae_n, ds;
	logic [10:0] almost_full_n, almost_empty_n;
	int          n_fail   = 0;
	int          compares = 0;
	int          cyc      = 0;

	always #50 clock_i = ~clock_i;

	mqaf_ctrl_model ctrl (.clock_i(clock_i), .write_queue_addr_o(wq), .write_addr_strobe_o(ws),
		.read_queue_addr_o(rq), .read_addr_strobe_o(rs));

	mqaf_top uut (.clock_i(clock_i), .rst_i(rst_i), .write_queue_addr_i(wq), .write_addr_strobe_i(ws),
		.write_en_i(we), .write_ready_o(wrdy), .read_queue_addr_i(rq), .read_addr_strobe_i(rs),
		.read_en_i(re), .default_select_i(ds), .prog_we_i(pwe), .prog_queue_i(pq),
		.prog_af_off_i(almost_full_n), .prog_ae_off_i(almost_empty_n), .almost_full_n_o(af_n), .almost_empty_n_o(ae_n));

	task close_out;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_fail++;
			close_out();
		end
	end

	// Back-to-back writes or reads; returns at the edge that takes the last one
	task wr(input int n);
		@(posedge clock_i);
		we <= 1'h1;
		repeat (n) @(posedge clock_i);
		we <= 1'h0;
	endtask : wr

	task rd(input int n);
		@(posedge clock_i);
		re <= 1'h1;
		repeat (n) @(posedge clock_i);
		re <= 1'h0;
	endtask : rd

	task prog(input logic [3:0] q, input logic [10:0] f, input logic [10:0] e);
		@(posedge clock_i);
		pwe <= 1'h1;
		pq  <= q;
		almost_full_n <= f;
		almost_empty_n <= e;
		@(posedge clock_i);
		pwe <= 1'h0;
	endtask : prog

	// Flag holds b after edge N+k-1 and shows a after edge N+k
	task chk_at(input int k, input logic sel, input logic b, input logic a);
		repeat (k - 1) @(posedge clock_i);
		@(negedge clock_i);
		`CHK(sel ? ae_n : af_n, b)
		@(posedge clock_i);
		@(negedge clock_i);
		`CHK(sel ? ae_n : af_n, a)
	endtask : chk_at

	task t_reset;
		@(negedge clock_i);
		`CHK(af_n, 1'h1)
		`CHK(ae_n, 1'h0)
		`CHK(wrdy, 1'h1)
		$display("t_reset done");
	endtask : t_reset

	task t_default;
		wr(8);
		wr(1);
		chk_at(4, 1'h1, 1'h0, 1'h1);
		rd(1);
		chk_at(2, 1'h1, 1'h1, 1'h0);
		`CHK(af_n, 1'h1)
		$display("t_default done");
	endtask : t_default

	task t_queues;
		prog(4'h3, 11'h3fe, 11'h0);
		ctrl.sel_w(4'h3);
		wr(1);
		wr(1);
		chk_at(4, 1'h0, 1'h1, 1'h0);
		ctrl.sel_w(4'h5);
		chk_at(2, 1'h0, 1'h0, 1'h1);
		ctrl.sel_r(4'h3);
		chk_at(2, 1'h1, 1'h0, 1'h1);
		rd(1);
		rd(1);
		chk_at(2, 1'h1, 1'h1, 1'h0);
		ctrl.sel_w(4'h3);
		chk_at(2, 1'h0, 1'h1, 1'h1);
		wr(2);
		chk_at(4, 1'h0, 1'h1, 1'h0);
		rd(1);
		chk_at(2, 1'h0, 1'h0, 1'h1);
		$display("t_queues done");
	endtask : t_queues

	// Mid-run reset with the strap high: defaults become 128
	task t_strap;
		@(posedge clock_i);
		ds    <= 1'h1;
		rst_i <= 1'h1;
		repeat (4) @(posedge clock_i);
		rst_i <= 1'h0;
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
		`CHK(af_n, 1'h1)
		`CHK(ae_n, 1'h0)
		wr(128);
		wr(1);
		chk_at(4, 1'h1, 1'h0, 1'h1);
		$display("t_strap done");
	endtask : t_strap

	initial
	begin
		{we, re, pwe, pq, almost_full_n, almost_empty_n, ds} = '0;
		repeat (4) @(posedge clock_i);
		rst_i <= 1'h0;
		repeat (2) @(posedge clock_i);
		t_reset();
		t_default();
		t_queues();
		t_strap();
		close_out();
	end
endmodule : mqaf_top_tb
